// ### inc/cbs_map.vh
`ifndef CBS_MAP_VH
`define CBS_MAP_VH

// Register byte addresses
`define CBS_ADDR_STATUS 4'h0
`define CBS_ADDR_PC 4'h4
`define CBS_ADDR_CTRL 4'h8
`define CBS_ADDR_INFO 4'hC

// Reset values
`define CBS_RST_STATUS 8'h00
`define CBS_RST_CTRL 1'h1
`define CBS_RST_LAST 2'h0

// Status register flag positions
`define CBS_FLAG_C 0
`define CBS_FLAG_Z 1
`define CBS_FLAG_N 2
`define CBS_FLAG_V 3
`define CBS_FLAG_S 4
`define CBS_FLAG_H 5
`define CBS_FLAG_T 6

// Information register field positions
`define CBS_INFO_BUSY 0
`define CBS_INFO_TAKEN 1
`define CBS_INFO_LAST_LO 4
`define CBS_INFO_LAST_HI 5

// Operation codes on the decoder port
`define CBS_OP_SKIP_IO_BIT_CLEAR 5'h00
`define CBS_OP_SKIP_IO_BIT_SET 5'h01
`define CBS_OP_BRANCH_SEL_FLAG_SET 5'h02
`define CBS_OP_BRANCH_SEL_FLAG_CLEAR 5'h03
`define CBS_OP_BRANCH_ON_EQUAL 5'h04
`define CBS_OP_BRANCH_ON_NOT_EQUAL 5'h05
`define CBS_OP_BRANCH_CARRY_SET 5'h06
`define CBS_OP_BRANCH_CARRY_CLEAR 5'h07
`define CBS_OP_BRANCH_UNSIGNED_SAME_HIGHER 5'h08
`define CBS_OP_BRANCH_UNSIGNED_LOWER 5'h09
`define CBS_OP_BRANCH_ON_MINUS 5'h0A
`define CBS_OP_BRANCH_ON_PLUS 5'h0B
`define CBS_OP_BRANCH_SIGNED_GE 5'h0C
`define CBS_OP_BRANCH_SIGNED_LESS 5'h0D
`define CBS_OP_BRANCH_HALF_CARRY_SET 5'h0E
`define CBS_OP_BRANCH_HALF_CARRY_CLEAR 5'h0F
`define CBS_OP_BRANCH_TRANSFER_BIT_SET 5'h10
`define CBS_OP_BRANCH_TRANSFER_BIT_CLEAR 5'h11
`define CBS_OP_BRANCH_OVERFLOW_SET 5'h12
`define CBS_OP_BRANCH_OVERFLOW_CLEAR 5'h13
`define CBS_OP_COMPARE_WITH_IMMEDIATE 5'h14

// Cycle costs reported in the information register
`define CBS_COST_ONE 2'h1
`define CBS_COST_TWO 2'h2
`define CBS_COST_THREE 2'h3

`endif

// ### logic/cbs_branch_skip.v
// Contract
// RULE1: skip_io_bit_clear skips the next instruction when the chosen I/O bit is 0.
// RULE2: skip_io_bit_set skips the next instruction when the chosen I/O bit is 1.
// RULE3: branch_sel_flag_set branches by offset plus one when selected flag is 1.
// RULE4: branch_sel_flag_clear branches by offset plus one when selected flag is 0.
// RULE5: branch_on_equal branches when the zero flag is 1.
// RULE6: branch_on_not_equal branches when the zero flag is 0.
// RULE7: Carry-set and unsigned-lower both branch when carry is 1.
// RULE8: Carry-clear and unsigned-same-or-higher both branch when carry is 0.
// RULE9: branch_on_minus branches when the negative flag is 1.
// RULE10: branch_on_plus branches when the negative flag is 0.
// RULE11: branch_signed_ge branches when negative XOR overflow is 0.
// RULE12: branch_signed_less branches when negative XOR overflow is 1.
// RULE13: branch_half_carry_set branches when the half-carry flag is 1.
// RULE14: branch_half_carry_clear branches when the half-carry flag is 0.
// RULE15: branch_transfer_bit_set branches when the transfer flag is 1.
// RULE16: branch_transfer_bit_clear branches when the transfer flag is 0.
// RULE17: branch_overflow_set branches when the overflow flag is 1.
// RULE18: branch_overflow_clear branches when overflow is 0; skips and branches keep flags.
// RULE19: compare_with_immediate subtracts without storing and updates Z, N, V, C, H.
// RULE20: Branch costs 1 cycle when not taken, 2 when taken.
// RULE21: Skip costs 1, 2 or 3 cycles by what is skipped.
// RULE22: Offset is sign-extended to program-counter width before the add.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`include "cbs_map.vh"

module cbs_branch_skip #(
    parameter PC_W = 16,
    parameter OFF_W = 7
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register bus
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Instruction issue from the decoder
    input wire instValid,
    output wire instReady,
    input wire [4:0] instOp,
    input wire [2:0] flagSel,
    input wire [2:0] bitSel,
    input wire [OFF_W-1:0] branchOffset,
    input wire nextTwoWord,
    input wire [7:0] ioData,
    input wire [7:0] cmpRegValue,
    input wire [7:0] cmpImmediate,
    // Program counter and status towards the core
    output wire [PC_W-1:0] pcOut,
    output wire [7:0] statusOut,
    output reg branchTaken
);

    localparam ST_IDLE = 2'h0;
    localparam ST_STALL1 = 2'h1;
    localparam ST_STALL2 = 2'h2;
    localparam [PC_W-1:0] PC_ONE = {{(PC_W-1){1'b0}}, 1'b1};
    localparam [PC_W-1:0] PC_TWO = {{(PC_W-2){1'b0}}, 2'b10};
    localparam [PC_W-1:0] PC_THREE = {{(PC_W-2){1'b0}}, 2'b11};

    reg [PC_W-1:0] pc_reg;
    reg [PC_W-1:0] pc_next;
    reg [7:0] status_reg;
    reg [7:0] status_next;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg enable_reg;
    reg [1:0] lastCost_reg;
    reg [1:0] lastCost_next;
    reg taken_reg;
    reg taken_next;
    reg resp_reg;

    // Evaluates the branch or skip condition of one operation
    function cond_true;
        input [4:0] op;
        input [7:0] flags;
        input [2:0] sel;
        input [7:0] io;
        input [2:0] ioBit;
        begin
            case (op)
                `CBS_OP_SKIP_IO_BIT_CLEAR: cond_true = ~io[ioBit]; // [RULE1]
                `CBS_OP_SKIP_IO_BIT_SET: cond_true = io[ioBit]; // [RULE2]
                `CBS_OP_BRANCH_SEL_FLAG_SET: cond_true = flags[sel]; // [RULE3]
                `CBS_OP_BRANCH_SEL_FLAG_CLEAR: cond_true = ~flags[sel]; // [RULE4]
                `CBS_OP_BRANCH_ON_EQUAL: cond_true = flags[`CBS_FLAG_Z]; // [RULE5]
                `CBS_OP_BRANCH_ON_NOT_EQUAL: cond_true = ~flags[`CBS_FLAG_Z]; // [RULE6]
                `CBS_OP_BRANCH_CARRY_SET,
                `CBS_OP_BRANCH_UNSIGNED_LOWER: cond_true = flags[`CBS_FLAG_C]; // [RULE7]
                `CBS_OP_BRANCH_CARRY_CLEAR,
                `CBS_OP_BRANCH_UNSIGNED_SAME_HIGHER: cond_true = ~flags[`CBS_FLAG_C]; // [RULE8]
                `CBS_OP_BRANCH_ON_MINUS: cond_true = flags[`CBS_FLAG_N]; // [RULE9]
                `CBS_OP_BRANCH_ON_PLUS: cond_true = ~flags[`CBS_FLAG_N]; // [RULE10]
                `CBS_OP_BRANCH_SIGNED_GE:
                    cond_true = ~(flags[`CBS_FLAG_N] ^ flags[`CBS_FLAG_V]); // [RULE11]
                `CBS_OP_BRANCH_SIGNED_LESS:
                    cond_true = flags[`CBS_FLAG_N] ^ flags[`CBS_FLAG_V]; // [RULE12]
                `CBS_OP_BRANCH_HALF_CARRY_SET: cond_true = flags[`CBS_FLAG_H]; // [RULE13]
                `CBS_OP_BRANCH_HALF_CARRY_CLEAR: cond_true = ~flags[`CBS_FLAG_H]; // [RULE14]
                `CBS_OP_BRANCH_TRANSFER_BIT_SET: cond_true = flags[`CBS_FLAG_T]; // [RULE15]
                `CBS_OP_BRANCH_TRANSFER_BIT_CLEAR: cond_true = ~flags[`CBS_FLAG_T]; // [RULE16]
                `CBS_OP_BRANCH_OVERFLOW_SET: cond_true = flags[`CBS_FLAG_V]; // [RULE17]
                `CBS_OP_BRANCH_OVERFLOW_CLEAR: cond_true = ~flags[`CBS_FLAG_V]; // [RULE18]
                default: cond_true = 1'b0;
            endcase
        end
    endfunction

    // Tells skips apart from branches
    function is_skip;
        input [4:0] op;
        begin
            is_skip = (op == `CBS_OP_SKIP_IO_BIT_CLEAR) || (op == `CBS_OP_SKIP_IO_BIT_SET);
        end
    endfunction

    // Relative target with the offset sign-extended
    wire [PC_W-1:0] offsetExt = {{(PC_W-OFF_W){branchOffset[OFF_W-1]}}, branchOffset}; // [RULE22]
    wire [PC_W-1:0] branchTarget = pc_reg + offsetExt + PC_ONE; // [RULE3]

    // Compare: difference is formed for the flags only and never stored
    wire [7:0] cmpDiff = cmpRegValue - cmpImmediate; // [RULE19]
    wire cmpC = cmpRegValue < cmpImmediate;
    wire cmpZ = (cmpDiff == 8'h00);
    wire cmpN = cmpDiff[7];
    wire cmpV = (cmpRegValue[7] & ~cmpImmediate[7] & ~cmpDiff[7]) |
                (~cmpRegValue[7] & cmpImmediate[7] & cmpDiff[7]);
    wire cmpH = (~cmpRegValue[3] & cmpImmediate[3]) | (cmpImmediate[3] & cmpDiff[3]) |
                (cmpDiff[3] & ~cmpRegValue[3]);

    assign instReady = (state_reg == ST_IDLE) && enable_reg;
    wire accept = instValid && instReady;
    wire condMet = cond_true(instOp, status_reg, flagSel, ioData, bitSel);

    // Byte-lane mask from the bus byte enables
    wire [31:0] laneMask;
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1)
        begin : gen_lane
            assign laneMask[lane*8 +: 8] = {8{avs_byteenable[lane]}};
        end
    endgenerate

    // Bus access completes on the second edge of each request; a write lands on that edge
    wire busReq = avs_read || avs_write;
    assign avs_waitrequest = busReq && !resp_reg;
    wire busWr = avs_write && resp_reg;
    wire [31:0] pcWide = {{(32-PC_W){1'b0}}, pc_reg};
    wire [31:0] pcMerged = (pcWide & ~laneMask) | (avs_writedata & laneMask);

    always @*
    begin
        pc_next = pc_reg;
        status_next = status_reg;
        state_next = state_reg;
        lastCost_next = lastCost_reg;
        taken_next = 1'b0;
        // Software writes first so that the core's own updates win
        if (busWr && avs_address == `CBS_ADDR_PC)
        begin
            pc_next = pcMerged[PC_W-1:0];
        end
        if (busWr && avs_address == `CBS_ADDR_STATUS && avs_byteenable[0])
        begin
            status_next = avs_writedata[7:0];
        end
        case (state_reg)
            ST_IDLE:
            begin
                if (accept)
                begin
                    lastCost_next = `CBS_COST_ONE;
                    pc_next = pc_reg + PC_ONE;
                    if (instOp == `CBS_OP_COMPARE_WITH_IMMEDIATE)
                    begin
                        status_next[`CBS_FLAG_C] = cmpC; // [RULE19]
                        status_next[`CBS_FLAG_Z] = cmpZ;
                        status_next[`CBS_FLAG_N] = cmpN;
                        status_next[`CBS_FLAG_V] = cmpV;
                        status_next[`CBS_FLAG_S] = cmpN ^ cmpV;
                        status_next[`CBS_FLAG_H] = cmpH;
                    end
                    else if (condMet && is_skip(instOp))
                    begin
                        taken_next = 1'b1;
                        if (nextTwoWord)
                        begin
                            pc_next = pc_reg + PC_THREE; // [RULE21]
                            state_next = ST_STALL2;
                            lastCost_next = `CBS_COST_THREE;
                        end
                        else
                        begin
                            pc_next = pc_reg + PC_TWO; // [RULE21]
                            state_next = ST_STALL1;
                            lastCost_next = `CBS_COST_TWO;
                        end
                    end
                    else if (condMet)
                    begin
                        taken_next = 1'b1;
                        pc_next = branchTarget; // [RULE20]
                        state_next = ST_STALL1;
                        lastCost_next = `CBS_COST_TWO;
                    end
                end
            end
            ST_STALL2:
            begin
                state_next = ST_STALL1;
            end
            ST_STALL1:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            pc_reg <= {PC_W{1'b0}};
            status_reg <= `CBS_RST_STATUS;
            state_reg <= ST_IDLE;
            lastCost_reg <= `CBS_RST_LAST;
            taken_reg <= 1'b0;
            branchTaken <= 1'b0;
        end
        else
        begin
            pc_reg <= pc_next;
            status_reg <= status_next; // [RULE18]
            state_reg <= state_next;
            lastCost_reg <= lastCost_next;
            if (accept)
            begin
                taken_reg <= taken_next;
            end
            branchTaken <= taken_next;
        end
    end

    // Bus slave: control register and read data
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            resp_reg <= 1'b0;
            enable_reg <= `CBS_RST_CTRL;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            resp_reg <= busReq && !resp_reg;
            if (busWr && avs_address == `CBS_ADDR_CTRL && avs_byteenable[0])
            begin
                enable_reg <= avs_writedata[0];
            end
            if (avs_read && !resp_reg)
            begin
                case (avs_address)
                    `CBS_ADDR_STATUS: avs_readdata <= {24'h000000, status_reg};
                    `CBS_ADDR_PC: avs_readdata <= pcWide;
                    `CBS_ADDR_CTRL: avs_readdata <= {31'h00000000, enable_reg};
                    `CBS_ADDR_INFO:
                    begin
                        avs_readdata <= 32'h00000000;
                        avs_readdata[`CBS_INFO_BUSY] <= (state_reg != ST_IDLE);
                        avs_readdata[`CBS_INFO_TAKEN] <= taken_reg;
                        avs_readdata[`CBS_INFO_LAST_HI:`CBS_INFO_LAST_LO] <= lastCost_reg;
                    end
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    assign pcOut = pc_reg;
    assign statusOut = status_reg;

endmodule

// ### dv/cbs_branch_skip_monitor.sv
module cbs_branch_skip_monitor #(
    parameter PC_W = 16,
    parameter OFF_W = 7
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register bus
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    // Instruction port
    input wire instValid,
    input wire instReady,
    input wire [4:0] instOp,
    input wire [2:0] bitSel,
    input wire [OFF_W-1:0] branchOffset,
    input wire nextTwoWord,
    input wire [7:0] ioData,
    input wire [7:0] cmpRegValue,
    input wire [7:0] cmpImmediate,
    // Core side
    input wire [PC_W-1:0] pcOut,
    input wire [7:0] statusOut,
    input wire branchTaken
);
    timeunit 1ns;
    timeprecision 100ps;
    wire acc = instValid && instReady;
    wire isBr = acc && instOp > 5'h01 && instOp < 5'h14;
    wire isSkip = acc && instOp < 5'h02;
    wire [PC_W-1:0] offX = {{(PC_W-OFF_W){branchOffset[OFF_W-1]}}, branchOffset};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence gapOne;
        !instReady ##1 instReady;
    endsequence
    sequence gapTwo;
        !instReady [*2] ##1 instReady;
    endsequence
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait cycle");
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    branch_pc_a: assert property (
        isBr |=> pcOut == $past(pcOut) + (branchTaken ? $past(offX) + 1'b1 : 1'b1))
        else $error("branch pc wrong");
    skip_pc_a: assert property (isSkip |=> pcOut == $past(pcOut) +
        (branchTaken ? ($past(nextTwoWord) ? 2'd3 : 2'd2) : 2'd1)) else $error("skip pc wrong");
    skip_bit_a: assert property (
        isSkip |=> branchTaken == ($past(ioData[bitSel]) ^ !$past(instOp[0])))
        else $error("skip test wrong");
    equal_cond_a: assert property (
        acc && instOp == 5'h04 |=> branchTaken == $past(statusOut[1])) else $error("equal wrong");
    signed_ge_a: assert property (
        acc && instOp == 5'h0C |=> branchTaken == !$past(statusOut[2] ^ statusOut[3]))
        else $error("signed ge wrong");
    flags_kept_a: assert property (acc && instOp != 5'h14 |=> $stable(statusOut))
        else $error("flags changed");
    cmp_zero_a: assert property (acc && instOp == 5'h14 |=>
        statusOut[1] == ($past(cmpRegValue) == $past(cmpImmediate))) else $error("zero wrong");
    br_stall_a: assert property (isBr ##1 branchTaken |-> gapOne)
        else $error("branch cost wrong");
    skip_stall_a: assert property (isSkip && nextTwoWord ##1 branchTaken |-> gapTwo)
        else $error("skip cost wrong");
    no_stall_a: assert property (acc ##1 !branchTaken |-> instReady)
        else $error("untaken stalled");
endmodule

bind cbs_branch_skip cbs_branch_skip_monitor #(.PC_W(PC_W), .OFF_W(OFF_W)) mon_u (
    .clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .instValid, .instReady,
    .instOp, .bitSel, .branchOffset, .nextTwoWord, .ioData, .cmpRegValue, .cmpImmediate,
    .pcOut, .statusOut, .branchTaken
);

// ### dv/cbs_fetch_model.sv
module cbs_fetch_model (
    // Clock and request
    input wire clk,
    input wire go,
    input wire [1:0] lag,
    // Decoder handshake
    input wire instReady,
    output logic instValid,
    output logic accepted
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = -1;
    initial
    begin
        instValid = 1'b0;
        accepted = 1'b0;
    end
    // Offers lag+1 cycles after go is sampled, then holds the offer until it is taken
    always @(posedge clk)
    begin
        accepted <= 1'b0;
        if (instValid && instReady)
        begin
            instValid <= 1'b0;
            accepted <= 1'b1;
        end
        else if (go)
            cnt <= lag;
        else if (cnt == 0)
        begin
            instValid <= 1'b1;
            cnt <= -1;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// ### dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic resetN = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0, avsWrite = 1'b0, avsWaitrequest;
    logic [31:0] avsWritedata = 32'h0, avsReaddata, q, seed = 32'h1BE4;
    logic go = 1'b0, twoWord = 1'b0, instValid, instReady, accepted, branchTaken;
    logic [1:0] lag = 2'h0;
    logic [4:0] op = 5'h00;
    logic [2:0] flagSel = 3'h0, bitSel = 3'h0;
    logic [6:0] offset = 7'h00;
    logic [7:0] ioData = 8'h00, regVal = 8'h00, immVal = 8'h00, statusOut, expSt = 8'h00;
    logic [15:0] pcOut;
    int fails = 0, compares = 0, expPc = 0;
    always #12.5 clk = ~clk;
    cbs_branch_skip dut_u (.clk(clk), .reset_n(resetN), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_byteenable(4'hF),
        .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .instValid(instValid), .instReady(instReady),
        .instOp(op), .flagSel(flagSel), .bitSel(bitSel), .branchOffset(offset),
        .nextTwoWord(twoWord), .ioData(ioData), .cmpRegValue(regVal), .cmpImmediate(immVal),
        .pcOut(pcOut), .statusOut(statusOut), .branchTaken(branchTaken));
    cbs_fetch_model fetch_u (.clk(clk), .go(go), .lag(lag), .instReady(instReady),
        .instValid(instValid), .accepted(accepted));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic cond(int o, logic [7:0] f, int fs, int bs, logic [7:0] io);
        logic s;
        case (o >> 1)
            0: s = io[bs];
            1: s = f[fs];
            2: s = f[1];
            3, 4: s = f[0];
            5: s = f[2];
            6: s = f[2] ^ f[3];
            7: s = f[5];
            8: s = f[6];
            default: s = f[3];
        endcase
        return s == (o inside {1, 2, 4, 6, 9, 10, 13, 14, 16, 18});
    endfunction
    function automatic logic [7:0] cmpFlags(logic [7:0] f, logic [7:0] a, logic [7:0] b);
        logic [7:0] s;
        s = a - b;
        f[0] = a < b;
        f[1] = s == 8'h00;
        f[2] = s[7];
        f[3] = (a[7] & !b[7] & !s[7]) | (!a[7] & b[7] & s[7]);
        f[4] = f[2] ^ f[3];
        f[5] = a[3:0] < b[3:0];
        return f;
    endfunction
    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avsWaitrequest !== 1'b0 && n < 20);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        if (avsWaitrequest !== 1'b0)
        begin
            fails++;
            final_report;
        end
    endtask
    task automatic issue(input logic [4:0] o);
        int n, d;
        logic [31:0] r;
        logic tk;
        r = rnd();
        @(posedge clk);
        op <= o;
        flagSel <= r[2:0];
        bitSel <= r[5:3];
        offset <= r[12:6];
        twoWord <= r[13];
        ioData <= r[21:14];
        regVal <= r[29:22];
        immVal <= r[14] ? r[29:22] : r[31:24];
        lag <= r[31:30];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (accepted !== 1'b1 && n < 40);
        if (accepted !== 1'b1)
        begin
            fails++;
            final_report;
        end
        tk = o < 5'h14 && cond(o, expSt, flagSel, bitSel, ioData);
        d = 1;
        if (tk)
            d = o < 5'h02 ? 2 + int'(twoWord) : int'($signed(offset)) + 1;
        expPc = (expPc + d) & 16'hFFFF;
        if (o == 5'h14)
            expSt = cmpFlags(expSt, regVal, immVal);
        chk(pcOut, expPc);
        chk(branchTaken, tk);
        chk(statusOut, expSt);
        bus(0, 4'hC, 0);
        chk({q[5:4], q[1]}, {(tk ? (o < 5'h02 ? 2'd2 + twoWord : 2'd2) : 2'd1), tk});
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        resetN <= 1'b1;
        chk(pcOut, 0);
        bus(0, 4'h0, 0);
        chk(q, 0);
        bus(0, 4'h8, 0);
        chk(q, 1);
        bus(0, 4'h1, 0);
        chk(q, 0);
        bus(1, 4'h8, 0);
        @(negedge clk);
        chk(instReady, 0);
        bus(1, 4'h8, 1);
        for (int o = 0; o < 21; o++)
            repeat (8)
            begin
                logic [31:0] r;
                r = rnd();
                expSt = r[7:0];
                bus(1, 4'h0, r);
                if (r[8])
                begin
                    expPc = r[31:16];
                    bus(1, 4'h4, r[31:16]);
                end
                issue(o[4:0]);
                if (r[9])
                    issue(o[4:0]);
            end
        bus(0, 4'h4, 0);
        chk(q, expPc);
        final_report;
    end
endmodule
